// ---- verilog/pec_pkg.sv ----
// Package for the partition error capture block: map, fields, codes, carriers
package pec_pkg;

    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int unsigned PID_W = 16;
    localparam int unsigned PMG_W = 8;
    localparam int unsigned RIS_W = 4;
    localparam int unsigned CODE_W = 4;
    localparam int unsigned ADDR_W = 12;

    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ECR_OFF = 12'h0F0;
    localparam logic [ADDR_W-1:0] ESR_OFF = 12'h0F8;
    localparam logic [ADDR_W-1:0] ESR_HI_OFF = 12'h0FC;
    localparam logic [ADDR_W-1:0] PSEL_OFF = 12'h100;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h104;
    localparam logic [ADDR_W-1:0] IMAP_OFF = 12'h108;
    localparam logic [ADDR_W-1:0] MSEL_OFF = 12'h200;
    localparam logic [ADDR_W-1:0] MCFG_OFF = 12'h204;
    localparam logic [ADDR_W-1:0] MVAL_OFF = 12'h208;
    localparam logic [ADDR_W-1:0] MCAP_OFF = 12'h20C;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int unsigned ESR_OVR_BIT = 31;
    localparam int unsigned ESR_CODE_LSB = 24;
    localparam int unsigned ESR_PMG_LSB = 16;
    localparam int unsigned ECR_EN_BIT = 0;
    localparam int unsigned SEL_INT_BIT = 16;
    localparam int unsigned SEL_RIS_LSB = 24;
    localparam int unsigned MCFG_PMG_LSB = 16;
    localparam int unsigned PPROT_NS_BIT = 1;

    // -------------------------------------------------------------------
    // Error codes, sentinel, response choices, zero word
    // -------------------------------------------------------------------
    localparam logic [CODE_W-1:0] ERR_NONE = 4'h0;
    localparam logic [CODE_W-1:0] ERR_PSEL_RANGE = 4'h1;
    localparam logic [CODE_W-1:0] ERR_REQ_PID = 4'h2;
    localparam logic [CODE_W-1:0] ERR_MCFG_ID = 4'h3;
    localparam logic [CODE_W-1:0] ERR_REQ_PMG = 4'h4;
    localparam logic [CODE_W-1:0] ERR_MON_RANGE = 4'h5;
    localparam logic [CODE_W-1:0] ERR_INTPID = 4'h6;
    localparam logic [CODE_W-1:0] ERR_UNEXP_INT = 4'h7;
    localparam logic [CODE_W-1:0] ERR_PSEL_RIS = 4'h8;
    localparam logic [CODE_W-1:0] ERR_NO_CTRL = 4'h9;
    localparam logic [CODE_W-1:0] ERR_MSEL_RIS = 4'hA;
    localparam logic [CODE_W-1:0] ERR_NO_MON = 4'hB;
    localparam logic [31:0] MON_SENTINEL = 32'hFFFF_FFFE;
    localparam logic [1:0] MON_RESP_SENTINEL = 2'h0;
    localparam logic [1:0] MON_RESP_RAZ = 2'h1;
    localparam logic [1:0] MON_RESP_RECORD = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // -------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic ns;
        logic [PID_W-1:0] partition_id;
        logic [PMG_W-1:0] monitor_group;
    } pec_req_t;

    typedef struct packed {
        logic ovr;
        logic [CODE_W-1:0] code;
        logic [PMG_W-1:0] monitor_group;
        logic [PID_W-1:0] pid_mon;
        logic [RIS_W-1:0] resource_instance_select;
    } pec_esr_t;

    typedef struct packed {
        logic hit;
        logic [CODE_W-1:0] code;
        logic [PMG_W-1:0] monitor_group;
        logic [PID_W-1:0] pid_mon;
        logic [RIS_W-1:0] resource_instance_select;
    } pec_err_t;

    typedef struct packed {
        pec_esr_t esr_s;
        pec_esr_t esr_ns;
        logic en_s;
        logic en_ns;
        logic [PID_W-1:0] psel_pid;
        logic psel_int;
        logic [RIS_W-1:0] psel_ris;
        logic [31:0] ctrl;
        logic [PID_W-1:0] imap_id;
        logic imap_int;
        logic [PID_W-1:0] msel_mon;
        logic [RIS_W-1:0] msel_ris;
        logic [PID_W-1:0] mcfg_pid;
        logic [PMG_W-1:0] mcfg_pmg;
        logic [31:0] mval;
        logic [31:0] mcap;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq_s;
        logic irq_ns;
        pec_req_t req_out;
        logic req_excl;
    } pec_state_t;

endpackage

// ---- verilog/pec_partition_error_capture.sv ----
// Partition error capture: APB register slave, request label checks, syndrome capture
`timescale 1ns/1ps

module pec_partition_error_capture #(
    parameter logic [15:0] PARTITION_ID_MAX_S = 16'h003F,
    parameter logic [15:0] PARTITION_ID_MAX_NS = 16'h003F,
    parameter logic [7:0] PMG_MAX_S = 8'h01,
    parameter logic [7:0] PMG_MAX_NS = 8'h01,
    parameter logic [15:0] DEF_PARTITION_ID = 16'h0000,
    parameter logic [7:0] DEF_PMG = 8'h00,
    parameter logic [15:0] INTPID_MAX = 16'h000F,
    parameter logic [15:0] MON_NUM = 16'h0001,
    parameter logic [4:0] RIS_NUM = 5'h02,
    parameter logic [15:0] CTRL_RIS_MASK = 16'h0001,
    parameter logic [15:0] MON_RIS_MASK = 16'h0001,
    parameter logic NARROW_PRESENT = 1'b1,
    parameter logic DET_PSEL_RIS = 1'b1,
    parameter logic DET_NO_CTRL = 1'b1,
    parameter logic DET_MSEL_RIS = 1'b1,
    parameter logic DET_NO_MON_OTHER = 1'b1,
    parameter logic [1:0] MON_ABSENT_RESP = pec_pkg::MON_RESP_RECORD,
    parameter logic EXCL_BAD_PMG = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pec_pkg::ADDR_W-1:0] paddr,
    input wire logic [2:0] pprot,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Labelled requests in and out
    input wire pec_pkg::pec_req_t req_i,
    output pec_pkg::pec_req_t req_o,
    output logic req_mon_excl,
    // Error interrupts
    output logic irq_s,
    output logic irq_ns
);
    import pec_pkg::*;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic pid_ok(input logic ns, input logic [PID_W-1:0] pid);
        return ns ? (pid <= PARTITION_ID_MAX_NS) : (pid <= PARTITION_ID_MAX_S);
    endfunction

    function automatic logic pmg_ok(input logic ns, input logic [PMG_W-1:0] monitor_group);
        return ns ? (monitor_group <= PMG_MAX_NS) : (monitor_group <= PMG_MAX_S);
    endfunction

    function automatic pec_err_t mk_err(input logic [CODE_W-1:0] code,
                                        input logic [PMG_W-1:0] monitor_group,
                                        input logic [PID_W-1:0] pid_mon,
                                        input logic [RIS_W-1:0] resource_instance_select);
        pec_err_t e;
        e.hit = 1'b1;
        e.code = code;
        e.monitor_group = monitor_group;
        e.pid_mon = pid_mon;
        e.resource_instance_select = resource_instance_select;
        return e;
    endfunction

    function automatic pec_esr_t rec1(input pec_esr_t e, input pec_err_t a);
        pec_esr_t r;
        r = e;
        if (a.hit) begin
            r.ovr = e.ovr | (e.code != ERR_NONE);
            r.code = a.code;
            r.monitor_group = a.monitor_group;
            r.pid_mon = a.pid_mon;
            r.resource_instance_select = a.resource_instance_select;
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] esr_word(input pec_esr_t e);
        return {e.ovr, 3'h0, e.code, e.monitor_group, e.pid_mon};
    endfunction

    // -------------------------------------------------------------------
    // Access decode and checks
    // -------------------------------------------------------------------
    pec_state_t s;
    pec_state_t d;
    logic ns_acc;
    logic blk;
    logic sent;
    logic mapped;
    logic [31:0] rdata;
    pec_err_t aerr;

    assign ns_acc = pprot[PPROT_NS_BIT];

    always_comb begin
        blk = 1'b0;
        sent = 1'b0;
        mapped = 1'b1;
        aerr = '0;
        rdata = WORD_ZERO;
        unique case (paddr)
            ECR_OFF: rdata = {31'h0000_0000, ns_acc ? s.en_ns : s.en_s};
            ESR_OFF: rdata = esr_word(ns_acc ? s.esr_ns : s.esr_s);
            ESR_HI_OFF: rdata = {28'h000_0000, ns_acc ? s.esr_ns.resource_instance_select : s.esr_s.resource_instance_select};
            PSEL_OFF: rdata = {4'h0, s.psel_ris, 7'h00, s.psel_int, s.psel_pid};
            MSEL_OFF: rdata = {4'h0, s.msel_ris, 8'h00, s.msel_mon};
            CTRL_OFF, IMAP_OFF: begin
                mapped = (paddr == CTRL_OFF) || NARROW_PRESENT;
                rdata = (paddr == CTRL_OFF) ? s.ctrl : {15'h0000, s.imap_int, s.imap_id};
                if ({1'b0, s.psel_ris} >= RIS_NUM) begin
                    blk = 1'b1;
                    if (DET_PSEL_RIS) begin
                        aerr = mk_err(ERR_PSEL_RIS, 8'h00, s.psel_pid, s.psel_ris);
                    end
                end else if (pwrite && !pid_ok(ns_acc, s.psel_pid)) begin
                    blk = 1'b1;
                    aerr = mk_err(ERR_PSEL_RANGE, 8'h00, s.psel_pid, s.psel_ris);
                end else if (paddr == CTRL_OFF && !CTRL_RIS_MASK[s.psel_ris]) begin
                    blk = 1'b1;
                    if (DET_NO_CTRL) begin
                        aerr = mk_err(ERR_NO_CTRL, 8'h00, s.psel_pid, s.psel_ris);
                    end
                end else if (NARROW_PRESENT) begin
                    if (paddr == IMAP_OFF && s.psel_int) begin
                        blk = 1'b1;
                        aerr = mk_err(ERR_UNEXP_INT, 8'h00, s.psel_pid, 4'h0);
                    end else if (paddr == IMAP_OFF && pwrite &&
                                 (!pwdata[SEL_INT_BIT] || pwdata[PID_W-1:0] > INTPID_MAX)) begin
                        blk = 1'b1;
                        aerr = mk_err(ERR_INTPID, 8'h00, pwdata[PID_W-1:0], 4'h0);
                    end else if (paddr == CTRL_OFF && !s.psel_int) begin
                        blk = 1'b1;
                        aerr = mk_err(ERR_INTPID, 8'h00, s.psel_pid, 4'h0);
                    end
                end
            end
            MCFG_OFF, MVAL_OFF, MCAP_OFF: begin
                unique case (paddr)
                    MCFG_OFF: rdata = {8'h00, s.mcfg_pmg, s.mcfg_pid};
                    MVAL_OFF: rdata = s.mval;
                    default: rdata = s.mcap;
                endcase
                if ({1'b0, s.msel_ris} >= RIS_NUM) begin
                    blk = 1'b1;
                    if (DET_MSEL_RIS) begin
                        aerr = mk_err(ERR_MSEL_RIS, 8'h00, s.msel_mon, s.msel_ris);
                    end
                end else if (!MON_RIS_MASK[s.msel_ris]) begin
                    blk = 1'b1;
                    if (paddr == MCFG_OFF) begin
                        if (DET_NO_MON_OTHER) begin
                            aerr = mk_err(ERR_NO_MON, 8'h00, s.msel_mon, s.msel_ris);
                        end
                    end else begin
                        sent = (MON_ABSENT_RESP == MON_RESP_SENTINEL);
                        if (MON_ABSENT_RESP == MON_RESP_RECORD) begin
                            aerr = mk_err(ERR_NO_MON, 8'h00, s.msel_mon, s.msel_ris);
                        end
                    end
                end else if (pwrite && s.msel_mon >= MON_NUM) begin
                    blk = 1'b1;
                    aerr = mk_err(ERR_MON_RANGE, 8'h00, s.msel_mon, s.msel_ris);
                end else if (paddr == MCFG_OFF && pwrite &&
                             (!pid_ok(ns_acc, pwdata[PID_W-1:0]) ||
                              !pmg_ok(ns_acc, pwdata[MCFG_PMG_LSB +: PMG_W]))) begin
                    blk = 1'b1;
                    aerr = mk_err(ERR_MCFG_ID, pwdata[MCFG_PMG_LSB +: PMG_W],
                                  pwdata[PID_W-1:0], s.msel_ris);
                end
            end
            default: mapped = 1'b0;
        endcase
        if (blk || !mapped) begin
            rdata = sent ? MON_SENTINEL : WORD_ZERO;
        end
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    logic setup;
    logic commit;
    logic wr_ok;
    logic [31:0] wm;
    pec_err_t rerr;
    pec_err_t aerr_s;
    pec_err_t aerr_ns;
    pec_err_t rerr_s;
    pec_err_t rerr_ns;

    always_comb begin
        d = s;
        setup = psel && !penable;
        commit = psel && penable && s.pready;
        wr_ok = commit && pwrite && mapped && !blk;
        d.pready = setup;
        if (setup) begin
            d.prdata = rdata;
            d.pslverr = !mapped;
        end
        // Request path always forwards the request
        d.req_out = req_i;
        d.req_excl = 1'b0;
        rerr = '0;
        if (req_i.valid && !pid_ok(req_i.ns, req_i.partition_id)) begin
            d.req_out.partition_id = DEF_PARTITION_ID;
            d.req_out.monitor_group = DEF_PMG;
            rerr = mk_err(ERR_REQ_PID, req_i.monitor_group, req_i.partition_id, 4'h0);
        end else if (req_i.valid && !pmg_ok(req_i.ns, req_i.monitor_group)) begin
            d.req_out.monitor_group = DEF_PMG;
            d.req_excl = EXCL_BAD_PMG;
            rerr = mk_err(ERR_REQ_PMG, req_i.monitor_group, req_i.partition_id, 4'h0);
        end
        // Monitor counts forwarded requests matching its filter, except those flagged by req_excl
        if (s.req_out.valid && !s.req_excl && s.req_out.partition_id == s.mcfg_pid &&
            s.req_out.monitor_group == s.mcfg_pmg) begin
            d.mval = s.mval + 32'h0000_0001;
        end
        wm = WORD_ZERO;
        if (wr_ok) begin
            unique case (paddr)
                ECR_OFF: begin
                    wm = merge({31'h0000_0000, ns_acc ? s.en_ns : s.en_s}, pwdata, pstrb);
                    if (ns_acc) d.en_ns = wm[ECR_EN_BIT];
                    else d.en_s = wm[ECR_EN_BIT];
                end
                ESR_OFF: begin
                    wm = merge(esr_word(ns_acc ? s.esr_ns : s.esr_s), pwdata, pstrb);
                    if (ns_acc) begin
                        d.esr_ns.ovr = wm[ESR_OVR_BIT];
                        d.esr_ns.code = wm[ESR_CODE_LSB +: CODE_W];
                        d.esr_ns.monitor_group = wm[ESR_PMG_LSB +: PMG_W];
                        d.esr_ns.pid_mon = wm[PID_W-1:0];
                    end else begin
                        d.esr_s.ovr = wm[ESR_OVR_BIT];
                        d.esr_s.code = wm[ESR_CODE_LSB +: CODE_W];
                        d.esr_s.monitor_group = wm[ESR_PMG_LSB +: PMG_W];
                        d.esr_s.pid_mon = wm[PID_W-1:0];
                    end
                end
                ESR_HI_OFF: begin
                    wm = merge({28'h000_0000, ns_acc ? s.esr_ns.resource_instance_select : s.esr_s.resource_instance_select},
                               pwdata, pstrb);
                    if (ns_acc) d.esr_ns.resource_instance_select = wm[RIS_W-1:0];
                    else d.esr_s.resource_instance_select = wm[RIS_W-1:0];
                end
                PSEL_OFF: begin
                    wm = merge({4'h0, s.psel_ris, 7'h00, s.psel_int, s.psel_pid}, pwdata, pstrb);
                    d.psel_pid = wm[PID_W-1:0];
                    d.psel_int = wm[SEL_INT_BIT];
                    d.psel_ris = wm[SEL_RIS_LSB +: RIS_W];
                end
                CTRL_OFF: d.ctrl = merge(s.ctrl, pwdata, pstrb);
                IMAP_OFF: begin
                    wm = merge({15'h0000, s.imap_int, s.imap_id}, pwdata, pstrb);
                    d.imap_id = wm[PID_W-1:0];
                    d.imap_int = wm[SEL_INT_BIT];
                end
                MSEL_OFF: begin
                    wm = merge({4'h0, s.msel_ris, 8'h00, s.msel_mon}, pwdata, pstrb);
                    d.msel_mon = wm[PID_W-1:0];
                    d.msel_ris = wm[SEL_RIS_LSB +: RIS_W];
                end
                MCFG_OFF: begin
                    wm = merge({8'h00, s.mcfg_pmg, s.mcfg_pid}, pwdata, pstrb);
                    d.mcfg_pid = wm[PID_W-1:0];
                    d.mcfg_pmg = wm[MCFG_PMG_LSB +: PMG_W];
                end
                MVAL_OFF: d.mval = merge(s.mval, pwdata, pstrb);
                default: d.mcap = s.mval;
            endcase
        end
        // Route errors per space; hardware record wins over a software write
        aerr_s = (commit && !ns_acc) ? aerr : '0;
        aerr_ns = (commit && ns_acc) ? aerr : '0;
        rerr_s = req_i.ns ? '0 : rerr;
        rerr_ns = req_i.ns ? rerr : '0;
        d.esr_s = rec1(rec1(d.esr_s, rerr_s), aerr_s);
        d.esr_ns = rec1(rec1(d.esr_ns, rerr_ns), aerr_ns);
        d.irq_s = d.en_s && (d.esr_s.code != ERR_NONE);
        d.irq_ns = d.en_ns && (d.esr_ns.code != ERR_NONE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= d;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign req_o = s.req_out;
    assign req_mon_excl = s.req_excl;
    assign irq_s = s.irq_s;
    assign irq_ns = s.irq_ns;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rsvd_code_a: assert property ((aerr_s.hit || rerr_s.hit) |=>
        s.esr_s.code inside {[1:11]}) else $error("reserved or zero code recorded");
    ovr_zero_a: assert property ((aerr_ns.hit || rerr_ns.hit) |=>
        !(s.esr_ns.ovr && s.esr_ns.code == ERR_NONE)) else $error("overwritten with zero code");
    ovr_set_a: assert property (s.esr_s.code != ERR_NONE && rerr_s.hit &&
        !(commit && pwrite && paddr == ESR_OFF && !ns_acc) |=> s.esr_s.ovr)
        else $error("overwritten flag not set");
    newest_wins_a: assert property (aerr_ns.hit |=>
        s.esr_ns.code == $past(aerr_ns.code) && s.esr_ns.pid_mon == $past(aerr_ns.pid_mon))
        else $error("syndrome not newest");
    req_pid_a: assert property (req_i.valid && req_i.ns &&
        !pid_ok(1'b1, req_i.partition_id) && !aerr_ns.hit |=>
        s.esr_ns.code == ERR_REQ_PID && s.req_out.partition_id == DEF_PARTITION_ID)
        else $error("request partition error missed");
    req_pass_a: assert property (req_i.valid |=>
        req_o.valid && req_o.ns == $past(req_i.ns)) else $error("request dropped");
    irq_gate_a: assert property (irq_s |->
        s.en_s && s.esr_s.code != ERR_NONE) else $error("interrupt without enable or error");
    raz_read_a: assert property (setup && !pwrite && blk && !sent |=>
        prdata == WORD_ZERO && pready) else $error("blocked read not zero");
    sentinel_a: assert property (setup && !pwrite && sent |=>
        prdata == MON_SENTINEL) else $error("sentinel not returned");
    psel_wi_a: assert property (commit && pwrite && paddr == CTRL_OFF && blk |=>
        $stable(s.ctrl)) else $error("blocked write took effect");

    ovr_cov_c: cover property (s.esr_s.code != ERR_NONE ##1 s.esr_s.ovr);
    req_err_c: cover property (rerr_ns.hit ##1 irq_ns);
    sentinel_c: cover property (setup && sent);
    mon_cnt_c: cover property (s.mval != WORD_ZERO);

endmodule

// ---- test/pec_req_source.sv ----
// Request source model: one labelled request per call
`timescale 1ns/1ps
module pec_req_source (
    // Clock and labelled request
    input wire logic pclk,
    output pec_pkg::pec_req_t req
);
    import pec_pkg::*;
    initial req = '0;
    task automatic send(input logic ns, input logic [15:0] pid, input logic [7:0] monitor_group);
        req <= '{valid: 1'b1, ns: ns, partition_id: pid, monitor_group: monitor_group};
        @(posedge pclk);
        req <= '{valid: 1'b0, ns: ~ns, partition_id: ~pid, monitor_group: ~monitor_group};
    endtask
endmodule

// ---- test/test_partition_error_capture.sv ----
// Bench for the partition error capture block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; \
    if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end \
end
module test_partition_error_capture;
    import pec_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [2:0] pprot = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, req_mon_excl, irq_s, irq_ns;
    pec_req_t req_i, req_o;
    int errors = 0, check_count = 0;
    pec_partition_error_capture uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pprot, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .req_i, .req_o, .req_mon_excl, .irq_s, .irq_ns);
    pec_req_source src (.pclk, .req(req_i));
    always #2 pclk = ~pclk;
    task automatic conclude(input int hung);
        errors += hung;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [2:0] pr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pprot <= pr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) conclude(1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic provoke(input logic [ADDR_W-1:0] sel_a, input logic [31:0] sel_v,
                           input logic w, input logic [ADDR_W-1:0] acc_a,
                           input logic [31:0] acc_d);
        apb(1'b1, 3'b010, sel_a, sel_v);
        apb(w, 3'b010, acc_a, acc_d);
    endtask
    task automatic check_cfg_errs();
        provoke(PSEL_OFF, 32'h0200_0000, 1'b0, CTRL_OFF, WORD_ZERO);
        `CHK("raz_ris", WORD_ZERO, prdata)
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_ris", 32'h8800_0000, prdata)
        apb(1'b0, 3'b010, ESR_HI_OFF, WORD_ZERO);
        `CHK("esr_hi", 32'h0000_0002, prdata)
        provoke(PSEL_OFF, 32'h0101_0000, 1'b0, CTRL_OFF, WORD_ZERO);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_noctl", 32'h8900_0000, prdata)
        provoke(PSEL_OFF, 32'h0001_0000, 1'b0, IMAP_OFF, WORD_ZERO);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_unexp", 32'h8700_0000, prdata)
        provoke(PSEL_OFF, WORD_ZERO, 1'b1, IMAP_OFF, 32'h0000_0005);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_intpid", 32'h8600_0005, prdata)
    endtask
    task automatic check_mon_errs();
        provoke(MSEL_OFF, 32'h0100_0000, 1'b0, MVAL_OFF, WORD_ZERO);
        `CHK("raz_mval", WORD_ZERO, prdata)
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_nomon", 32'h8B00_0000, prdata)
        provoke(MSEL_OFF, 32'h0200_0000, 1'b0, MCFG_OFF, WORD_ZERO);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_mris", 32'h8A00_0000, prdata)
        provoke(MSEL_OFF, 32'h0000_0001, 1'b1, MCFG_OFF, WORD_ZERO);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_mon", 32'h8500_0001, prdata)
        provoke(MSEL_OFF, WORD_ZERO, 1'b1, MCFG_OFF, 32'h0002_0005);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_mcfg", 32'h8302_0005, prdata)
        apb(1'b0, 3'b010, MCFG_OFF, WORD_ZERO);
        `CHK("mcfg_wi", WORD_ZERO, prdata)
    endtask
    task automatic check_psel();
        apb(1'b1, 3'b010, PSEL_OFF, 32'h0000_0040);
        apb(1'b1, 3'b010, CTRL_OFF, 32'h0000_00AA);
        apb(1'b0, 3'b010, ESR_OFF, WORD_ZERO);
        `CHK("esr_ns", 32'h0100_0040, prdata)
        apb(1'b0, 3'b000, ESR_OFF, WORD_ZERO);
        `CHK("esr_s", WORD_ZERO, prdata)
        `CHK("irq_ns", 1'b0, irq_ns)
        apb(1'b0, 3'b000, 12'h300, WORD_ZERO);
        `CHK("pslverr", 1'b1, pslverr)
    endtask
    task automatic check_req_pid();
        apb(1'b1, 3'b000, ECR_OFF, 32'h0000_0001);
        src.send(1'b0, 16'h0040, 8'h01);
        #1;
        `CHK("req_pid", 16'h0000, req_o.partition_id)
        `CHK("req_valid", 1'b1, req_o.valid)
        `CHK("irq_s", 1'b1, irq_s)
        @(posedge pclk);
        apb(1'b0, 3'b000, ESR_OFF, WORD_ZERO);
        `CHK("esr_s", 32'h0201_0040, prdata)
    endtask
    task automatic check_req_pmg();
        src.send(1'b0, 16'h0005, 8'h02);
        #1;
        `CHK("req_excl", 1'b1, req_mon_excl)
        `CHK("req_pmg", 8'h00, req_o.monitor_group)
        @(posedge pclk);
        apb(1'b0, 3'b000, ESR_OFF, WORD_ZERO);
        `CHK("esr_s", 32'h8402_0005, prdata)
        apb(1'b1, 3'b000, ESR_OFF, WORD_ZERO);
        `CHK("irq_s", 1'b0, irq_s)
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_psel();
        check_cfg_errs();
        check_mon_errs();
        check_req_pid();
        check_req_pmg();
        conclude(0);
    end
endmodule
